//--- logic/led_pwm_pkg.sv
// constants and helpers shared by the grayscale pwm and current scale logic
// Notes on behaviour
// RL1 - one 7-bit scale shared by all sixteen channels
// RL2 - current ratio is quarter plus three quarters scaled
// RL3 - scale comes from second control latch, 00h-7Fh
// RL4 - controller writes scale before enabling outputs
// RL5 - each channel holds its own 12-bit gray level
// RL6 - shared counter advances on each count clock rise
// RL7 - output disable clears and holds counter at zero
// RL8 - select bit picks conventional or spread modulation
// RL9 - on-time equals gray level count clock periods
// RL10 - output disable bit is set at reset
// RL11 - controller loads gray latches before enabling outputs
// RL12 - all sinks off while output disable is set
// RL13 - first edge after enable lights nonzero channels
// RL14 - conventional channel off once counter exceeds level
// RL15 - load with restart bit restarts the period
// RL16 - auto repeat restarts period at 4096th edge
// RL17 - ended period stays dark until disable or restart
// RL18 - spread mode uses 32 segments of 128 clocks
// RL19 - spread units added in bit-reversed segment order
// RL20 - without repeat counter stops after 4096th edge
package led_pwm_pkg;

	localparam int          CHANNELS      = 16;
	localparam int          GRAY_W        = 12;
	localparam int          SCALE_W       = 7;
	localparam int          INDEX_W       = 4;
	localparam int          RATIO_W       = 9;
	localparam int          SEG_W         = 5;
	localparam int          SLOT_W        = 7;
	localparam logic [11:0] COUNT_ZERO    = 12'h000;
	localparam logic [11:0] COUNT_LAST    = 12'hFFF;
	localparam logic [11:0] COUNT_STEP    = 12'h001;
	localparam logic [8:0]  RATIO_BASE    = 9'h07F;
	localparam logic [1:0]  RATIO_MULT    = 2'h3;
	localparam logic [8:0]  RATIO_DENOM   = 9'h1FC;
	localparam logic        DISABLE_RESET = 1'b1;
	localparam logic        MODE_RESET    = 1'b0;
	localparam logic [6:0]  SCALE_RESET   = 7'h00;
	localparam logic [11:0] GRAY_RESET    = 12'h000;

	typedef enum logic [1:0] {
		PH_BLANK = 2'b00,
		PH_RUN   = 2'b01,
		PH_DONE  = 2'b10
	} phase_t;

	// segment rank in the spread order is the bit-reversed segment number
	function automatic logic [4:0] bit_reverse5(input logic [4:0] v);
		bit_reverse5 = {v[0], v[1], v[2], v[3], v[4]};
	endfunction

	// sink current as a fraction of the maximum, numerator over RATIO_DENOM
	function automatic logic [8:0] current_ratio(input logic [6:0] scale);
		current_ratio = RATIO_BASE + 9'(RATIO_MULT * scale);
	endfunction

endpackage

//--- logic/channel_compare.sv
// per-channel on decision for conventional and spread modulation
module channel_compare (
	input  wire logic [11:0] gray,
	input  wire logic [11:0] count,
	input  wire logic        spread,
	output logic             on
);

	wire logic [11:0] pos        = count - led_pwm_pkg::COUNT_STEP;
	wire logic [4:0]  segment    = pos[11:7];
	wire logic [6:0]  slot       = pos[6:0];
	wire logic [4:0]  rank       = led_pwm_pkg::bit_reverse5(segment);
	wire logic [7:0]  slots_here = {1'b0, gray[11:5]} + {7'h00, (rank < gray[4:0])}; // RL19
	wire logic        counting   = (count != led_pwm_pkg::COUNT_ZERO);
	wire logic        conv_on    = counting && (count <= gray); // RL14
	wire logic        spread_on  = counting && ({1'b0, slot} < slots_here); // RL18

	// both schemes light a channel for exactly gray clocks per period
	assign on = spread ? spread_on : conv_on; // RL8 RL9

endmodule

//--- logic/led_grayscale_pwm_brightness.sv
// grayscale pwm counter, gray and control latches, global current scale
module led_grayscale_pwm_brightness (
	input  wire logic        REF_CLK,
	input  wire logic        ARST_N,
	input  wire logic        PWM_COUNT_CLOCK,
	input  wire logic        GRAY_WRITE,
	input  wire logic [3:0]  GRAY_WRITE_INDEX,
	input  wire logic [11:0] GRAY_WRITE_DATA,
	input  wire logic        LOAD_STROBE,
	input  wire logic        CONTROL_LOAD,
	input  wire logic        OUTPUT_DISABLE_IN,
	input  wire logic        SPREAD_MODULATION_SELECT,
	input  wire logic        TIMING_RESTART_BIT,
	input  wire logic        AUTO_REPEAT_BIT,
	input  wire logic        SCALE_LOAD,
	input  wire logic [6:0]  GLOBAL_CURRENT_SCALE_IN,
	output logic      [15:0] SINK_CHANNEL,
	output logic      [6:0]  GLOBAL_CURRENT_SCALE,
	output logic      [8:0]  CURRENT_RATIO_NUM,
	output logic             OUTPUT_DISABLE,
	output logic      [11:0] GRAY_COUNT
);

	localparam int N = led_pwm_pkg::CHANNELS;

	// first gray latch takes writes, second one drives the compare
	logic [11:0]         gray_first_q [N];
	logic [11:0]         gray_disp_q  [N];
	logic                disable_q;
	logic                spread_q;
	logic                restart_q;
	logic                repeat_q;
	logic [6:0]          scale_first_q;
	logic [6:0]          scale_q;
	logic [8:0]          ratio_q;
	logic                clk_prev_q;
	logic [11:0]         cnt_q;
	logic [11:0]         cnt_d;
	led_pwm_pkg::phase_t phase_q;
	led_pwm_pkg::phase_t phase_d;
	logic [15:0]         sink_q;
	logic [15:0]         sink_d;
	logic [15:0]         hit;
	logic [15:0]         nz_mask;

	// the count clock is synchronous to REF_CLK, so a registered copy gives the edge
	wire logic count_edge    = PWM_COUNT_CLOCK && !clk_prev_q; // RL6
	wire logic running       = (phase_q == led_pwm_pkg::PH_RUN) && !disable_q;
	wire logic period_end    = count_edge && running && (cnt_q == led_pwm_pkg::COUNT_LAST);
	wire logic load_restart  = LOAD_STROBE && restart_q; // RL15
	wire logic repeat_pulse  = period_end && repeat_q; // RL16
	wire logic restart_pulse = load_restart || repeat_pulse;
	wire logic advance       = count_edge && running && !restart_pulse;
	wire logic sinks_live    = (phase_d == led_pwm_pkg::PH_RUN) && !disable_q;

	// phase: blank while disabled, run while counting, done after a period without repeat
	always_comb begin
		phase_d = phase_q;
		unique case (phase_q)
			led_pwm_pkg::PH_BLANK: begin
				if (!disable_q)
					phase_d = led_pwm_pkg::PH_RUN;
			end
			led_pwm_pkg::PH_RUN: begin
				if (period_end && !repeat_q)
					phase_d = led_pwm_pkg::PH_DONE; // RL20
			end
			led_pwm_pkg::PH_DONE: begin
				phase_d = led_pwm_pkg::PH_DONE; // RL17
			end
			default: begin
				phase_d = led_pwm_pkg::PH_BLANK;
			end
		endcase
		if (disable_q)
			phase_d = led_pwm_pkg::PH_BLANK;
		else if (restart_pulse)
			phase_d = led_pwm_pkg::PH_RUN; // RL15 RL16
	end

	// counter is cleared by disable or a restart, stalls when the period is done
	always_comb begin
		cnt_d = cnt_q;
		if (disable_q || restart_pulse)
			cnt_d = led_pwm_pkg::COUNT_ZERO; // RL7
		else if (advance)
			cnt_d = cnt_q + led_pwm_pkg::COUNT_STEP; // RL6
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_ch
			channel_compare u_cmp (
				.gray   (gray_disp_q[g]),
				.count  (cnt_d),
				.spread (spread_q),
				.on     (hit[g])
			);
			assign nz_mask[g] = (gray_disp_q[g] != led_pwm_pkg::GRAY_RESET);
		end
	endgenerate

	// decide on the next counter value so the sinks change in the same cycle as the count
	assign sink_d = sinks_live ? hit : 16'h0000; // RL12 RL13 RL17

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < N; i++) begin
				gray_first_q[i] <= led_pwm_pkg::GRAY_RESET;
				gray_disp_q[i]  <= led_pwm_pkg::GRAY_RESET;
			end
		end else begin
			if (GRAY_WRITE)
				gray_first_q[GRAY_WRITE_INDEX] <= GRAY_WRITE_DATA; // RL5
			if (LOAD_STROBE) begin
				for (int i = 0; i < N; i++)
					gray_disp_q[i] <= gray_first_q[i];
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			disable_q <= led_pwm_pkg::DISABLE_RESET; // RL10
			spread_q  <= led_pwm_pkg::MODE_RESET;
			restart_q <= led_pwm_pkg::MODE_RESET;
			repeat_q  <= led_pwm_pkg::MODE_RESET;
		end else if (CONTROL_LOAD) begin
			disable_q <= OUTPUT_DISABLE_IN;
			spread_q  <= SPREAD_MODULATION_SELECT; // RL8
			restart_q <= TIMING_RESTART_BIT;
			repeat_q  <= AUTO_REPEAT_BIT;
		end
	end

	// scale is staged in the first latch and applied from the second on LOAD_STROBE
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			scale_first_q <= led_pwm_pkg::SCALE_RESET;
			scale_q       <= led_pwm_pkg::SCALE_RESET;
			ratio_q       <= led_pwm_pkg::RATIO_BASE;
		end else begin
			if (SCALE_LOAD)
				scale_first_q <= GLOBAL_CURRENT_SCALE_IN;
			if (LOAD_STROBE) begin
				scale_q <= scale_first_q; // RL3 RL1
				ratio_q <= led_pwm_pkg::current_ratio(scale_first_q); // RL2
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			clk_prev_q <= 1'b0;
			cnt_q      <= led_pwm_pkg::COUNT_ZERO;
			phase_q    <= led_pwm_pkg::PH_BLANK;
			sink_q     <= 16'h0000;
		end else begin
			clk_prev_q <= PWM_COUNT_CLOCK;
			cnt_q      <= cnt_d;
			phase_q    <= phase_d;
			sink_q     <= sink_d;
		end
	end

	assign SINK_CHANNEL         = sink_q;
	assign GLOBAL_CURRENT_SCALE = scale_q;
	assign CURRENT_RATIO_NUM    = ratio_q;
	assign OUTPUT_DISABLE       = disable_q;
	assign GRAY_COUNT           = cnt_q;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!ARST_N);

	sequence s_first_count;
		count_edge && running && !restart_pulse && !LOAD_STROBE && !spread_q
			&& (cnt_q == led_pwm_pkg::COUNT_ZERO);
	endsequence

	sequence s_period_end_repeat;
		period_end && repeat_q && !disable_q;
	endsequence

	sequence s_period_end_stop;
		period_end && !repeat_q && !LOAD_STROBE;
	endsequence

	a_disable_clears: assert property (disable_q |=> (GRAY_COUNT == 12'h000)) // RL7
		else $error("counter not cleared while output disable is set");

	a_disable_dark: assert property (disable_q |=> (SINK_CHANNEL == 16'h0000)) // RL12
		else $error("sink on while output disable is set");

	a_count_step: assert property (advance |=> (GRAY_COUNT == $past(cnt_q) + 12'h001)) // RL6
		else $error("counter did not advance on count clock edge");

	a_first_lights: assert property (s_first_count |=> (SINK_CHANNEL == $past(nz_mask))) // RL13
		else $error("first count edge did not light nonzero channels");

	a_conv_off: assert property (
		(!spread_q && advance && !LOAD_STROBE && sink_q[1] && (cnt_q == gray_disp_q[1]))
			|=> !SINK_CHANNEL[1]) // RL14
		else $error("conventional channel stayed on past its level");

	a_load_restart: assert property ((load_restart && !disable_q)
		|=> (GRAY_COUNT == 12'h000) && (SINK_CHANNEL == 16'h0000) && (phase_q == led_pwm_pkg::PH_RUN)) // RL15
		else $error("load with restart bit did not restart period");

	a_repeat_wrap: assert property (s_period_end_repeat
		|=> (GRAY_COUNT == 12'h000) && (phase_q == led_pwm_pkg::PH_RUN)) // RL16
		else $error("auto repeat did not restart period");

	a_stop_hold: assert property (s_period_end_stop
		|=> (phase_q == led_pwm_pkg::PH_DONE) ##1 ((SINK_CHANNEL == 16'h0000) || disable_q || $past(LOAD_STROBE))) // RL20
		else $error("period without repeat did not stop dark");

	a_done_dark: assert property ((phase_q == led_pwm_pkg::PH_DONE) && !restart_pulse
		|=> (SINK_CHANNEL == 16'h0000) && (GRAY_COUNT == $past(cnt_q))) // RL17
		else $error("ended period lit again without restart");

	a_scale_ratio: assert property ($rose(LOAD_STROBE) |=>
		(CURRENT_RATIO_NUM == 9'h07F + 9'(3 * GLOBAL_CURRENT_SCALE))) // RL2
		else $error("current ratio does not match scale");

	// checking aid: on-time of channel 1 in count slots over one period
	// a mid-period load or mode change makes the period uneven, so the check skips it
	logic [12:0] on_slots_q;
	logic        level_steady_q;

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			on_slots_q     <= 13'h0000;
			level_steady_q <= 1'b1;
		end else if (disable_q || restart_pulse) begin
			on_slots_q     <= 13'h0000;
			level_steady_q <= 1'b1;
		end else begin
			if (advance && hit[1])
				on_slots_q <= on_slots_q + 13'h0001;
			if (LOAD_STROBE || CONTROL_LOAD)
				level_steady_q <= 1'b0;
		end
	end

	sequence s_spread_first;
		count_edge && running && !restart_pulse && !LOAD_STROBE && spread_q
			&& (cnt_q == led_pwm_pkg::COUNT_ZERO);
	endsequence

	a_on_time: assert property ((period_end && level_steady_q) |-> (on_slots_q == {1'b0, gray_disp_q[1]})) // RL9
		else $error("channel on-time over a period differs from its level");

	a_spread_lights: assert property (s_spread_first |=> (SINK_CHANNEL == $past(nz_mask))) // RL19
		else $error("first spread slot did not light nonzero channels");

	a_conv_on_hold: assert property (
		(!spread_q && advance && !LOAD_STROBE && (cnt_q < gray_disp_q[1])) |=> SINK_CHANNEL[1]) // RL14
		else $error("conventional channel went off before its level");

	a_full_on: assert property (
		(!spread_q && advance && (gray_disp_q[14] == 12'hFFF) && (cnt_q != 12'hFFF)) |=> SINK_CHANNEL[14]) // RL14
		else $error("full level channel went off inside the period");

	a_zero_dark: assert property ((gray_disp_q[0] == 12'h000) |=> !SINK_CHANNEL[0]) // RL5
		else $error("channel with zero level turned on");

	a_count_hold: assert property ((!advance && !disable_q && !restart_pulse) |=> (GRAY_COUNT == $past(cnt_q))) // RL6
		else $error("counter moved without a count clock edge");

	a_blank_phase: assert property (disable_q |=> (phase_q == led_pwm_pkg::PH_BLANK)) // RL7
		else $error("phase not blank while output disable is set");

	a_gray_write: assert property ((GRAY_WRITE && (GRAY_WRITE_INDEX == 4'h1))
		|=> (gray_first_q[1] == $past(GRAY_WRITE_DATA))) // RL5
		else $error("gray write did not reach the first latch");

	a_gray_copy: assert property (LOAD_STROBE |=> (gray_disp_q[1] == $past(gray_first_q[1]))) // RL5
		else $error("load strobe did not copy gray level to display latch");

	a_scale_copy: assert property (LOAD_STROBE |=> (GLOBAL_CURRENT_SCALE == $past(scale_first_q))) // RL3
		else $error("load strobe did not apply the staged scale");

	a_scale_hold: assert property (!LOAD_STROBE |=> $stable(GLOBAL_CURRENT_SCALE) && $stable(CURRENT_RATIO_NUM)) // RL1
		else $error("applied scale changed without load strobe");

	a_ratio_range: assert property ((CURRENT_RATIO_NUM >= 9'h07F) && (CURRENT_RATIO_NUM <= 9'h1FC)) // RL2
		else $error("current ratio outside quarter to full range");

	a_ctrl_hold: assert property (!CONTROL_LOAD |=> $stable(OUTPUT_DISABLE) && $stable(spread_q)) // RL8
		else $error("control bits changed without control load");

	a_ctrl_take: assert property (CONTROL_LOAD |=> (OUTPUT_DISABLE == $past(OUTPUT_DISABLE_IN))
		&& (spread_q == $past(SPREAD_MODULATION_SELECT))) // RL8
		else $error("control load did not capture control bits");

	a_done_stays: assert property (((phase_q == led_pwm_pkg::PH_DONE) && !disable_q && !restart_pulse)
		|=> (phase_q == led_pwm_pkg::PH_DONE)) // RL17
		else $error("ended period left the done phase without disable or restart");

	a_repeat_dark: assert property (s_period_end_repeat |=> (SINK_CHANNEL == 16'h0000)) // RL16
		else $error("sinks lit in the restart slot of a repeated period");

endmodule

//--- test/count_clock_source.sv
// display controller stand-in that makes the grayscale count clock in bursts
module count_clock_source (
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic [3:0] half,
	output logic            gclk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] tick_q;
	initial begin
		gclk = 1'b0;
		tick_q = 4'h0;
	end
	// parked low between bursts so no stray count edge reaches the counter
	always @(posedge clk) begin
		#1;
		if (!run) begin
			gclk = 1'b0;
			tick_q = 4'h0;
		end else if (tick_q == half) begin
			gclk = ~gclk;
			tick_q = 4'h0;
		end else begin
			tick_q = tick_q + 4'h1;
		end
	end
endmodule

//--- test/tb_top.sv
// self-checking bench for the grayscale pwm and current scale block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic sp; int n;} row_t;
	logic clk, arst_n, gclk, run, gwr, lat, cload, dis_in, sp_in, tr_in, rp_in, sload;
	logic [3:0]  gidx, half;
	logic [11:0] gdata, count;
	logic [6:0]  scale_in, scale;
	logic [15:0] sink;
	logic [8:0]  ratio;
	logic        dis;
	int          err_count, n_tests;
	logic [11:0] gray [16] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h01F, 12'h020, 12'h021, 12'h03F,
		12'h040, 12'h041, 12'h080, 12'h081, 12'hFE0, 12'hFFE, 12'hFFF, 12'h011};
	row_t rows [11] = '{'{1'b0, 1}, '{1'b0, 2}, '{1'b0, 3}, '{1'b0, 65}, '{1'b0, 129}, '{1'b1, 1},
		'{1'b1, 2}, '{1'b1, 130}, '{1'b1, 1026}, '{1'b1, 2178}, '{1'b1, 3969}};
	logic [6:0] scales [4] = '{7'h00, 7'h01, 7'h7E, 7'h7F};

	count_clock_source src (.clk(clk), .run(run), .half(half), .gclk(gclk));
	led_grayscale_pwm_brightness dut (.REF_CLK(clk), .ARST_N(arst_n), .PWM_COUNT_CLOCK(gclk), .GRAY_WRITE(gwr),
		.GRAY_WRITE_INDEX(gidx), .GRAY_WRITE_DATA(gdata), .LOAD_STROBE(lat), .CONTROL_LOAD(cload),
		.OUTPUT_DISABLE_IN(dis_in), .SPREAD_MODULATION_SELECT(sp_in), .TIMING_RESTART_BIT(tr_in),
		.AUTO_REPEAT_BIT(rp_in), .SCALE_LOAD(sload), .GLOBAL_CURRENT_SCALE_IN(scale_in),
		.SINK_CHANNEL(sink), .GLOBAL_CURRENT_SCALE(scale), .CURRENT_RATIO_NUM(ratio),
		.OUTPUT_DISABLE(dis), .GRAY_COUNT(count));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic wrap_up();
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic ctrl(input logic d, input logic s, input logic t, input logic r);
		{dis_in, sp_in, tr_in, rp_in} = {d, s, t, r};
		cload = 1'b1;
		tick();
		cload = 1'b0;
		tick();
	endtask

	task automatic strobe_load();
		lat = 1'b1;
		tick();
		lat = 1'b0;
		tick();
	endtask

	// stops the source right after the nth rise, then lets the counter settle
	task automatic pulses(input int n);
		run = 1'b1;
		repeat (n) @(posedge gclk);
		run = 1'b0;
		repeat (3) tick();
	endtask

	function automatic logic [15:0] expect_sink(input logic sp, input int k);
		logic [11:0] p;
		logic [4:0]  s;
		expect_sink = 16'h0000;
		p = 12'(k - 1);
		s = p[11:7];
		for (int c = 0; c < 16; c++)
			if (sp) expect_sink[c] = {1'b0, p[6:0]} < {1'b0, gray[c][11:5]} + 8'({s[0], s[1], s[2], s[3], s[4]} < gray[c][4:0]);
			else expect_sink[c] = k >= 1 && k <= int'(gray[c]);
	endfunction

	initial begin
		#900000;
		err_count++;
		wrap_up();
	end

	initial begin
		{arst_n, run, gwr, lat, cload, dis_in, sp_in, tr_in, rp_in, sload} = 10'h0;
		{gidx, gdata, scale_in, half} = {4'h0, 12'h000, 7'h00, 4'h1};
		repeat (10) @(posedge clk);
		#1;
		arst_n = 1'b1;
		check({15'h0, dis}, 16'h0001);
		check(sink, 16'h0000);
		check({7'h0, ratio}, 16'h007F);
		pulses(3);
		check({4'h0, count}, 16'h0000);
		foreach (scales[i]) begin
			scale_in = scales[i];
			sload = 1'b1;
			tick();
			sload = 1'b0;
			strobe_load();
			check({9'h0, scale}, {9'h0, scales[i]});
			check({7'h0, ratio}, 16'(127 + 3 * scales[i]));
		end
		for (int c = 0; c < 16; c++) begin
			{gidx, gdata, gwr} = {4'(c), gray[c], 1'b1};
			tick();
		end
		gwr = 1'b0;
		strobe_load();
		foreach (rows[i]) begin
			ctrl(1'b1, rows[i].sp, 1'b0, 1'b0);
			check(sink, 16'h0000);
			ctrl(1'b0, rows[i].sp, 1'b0, 1'b0);
			pulses(rows[i].n);
			check({4'h0, count}, 16'(rows[i].n));
			check(sink, expect_sink(rows[i].sp, rows[i].n));
		end
		ctrl(1'b0, 1'b0, 1'b1, 1'b0);
		pulses(5);
		strobe_load();
		check({4'h0, count}, 16'h0000);
		check(sink, 16'h0000);
		pulses(1);
		check(sink, expect_sink(1'b0, 1));
		half = 4'h0;
		ctrl(1'b1, 1'b0, 1'b0, 1'b1);
		ctrl(1'b0, 1'b0, 1'b0, 1'b1);
		pulses(4097);
		check({4'h0, count}, 16'h0001);
		ctrl(1'b1, 1'b0, 1'b0, 1'b0);
		ctrl(1'b0, 1'b0, 1'b0, 1'b0);
		pulses(4096);
		check(sink, 16'h0000);
		pulses(2);
		check({4'h0, count}, 16'h0000);
		ctrl(1'b1, 1'b0, 1'b0, 1'b0);
		ctrl(1'b0, 1'b0, 1'b0, 1'b0);
		pulses(1);
		check({4'h0, count}, 16'h0001);
		arst_n = 1'b0;
		tick();
		arst_n = 1'b1;
		check({15'h0, dis}, 16'h0001);
		check({4'h0, count}, 16'h0000);
		check(sink, 16'h0000);
		check({9'h0, scale}, 16'h0000);
		check({7'h0, ratio}, 16'h007F);
		pulses(2);
		check({4'h0, count}, 16'h0000);
		wrap_up();
	end
endmodule
